// [hdl/xdata_port_map.svh]
//
// Contract
// - pointer select picks data pointer zero or one
// - extension bytes used only by external moves
// - pointer moves take top byte from pointer extension
// - indirect moves take high and middle extension bytes
// - external data address is 24 bits wide
// - each fast port: data, select, pin state
// - fast access only ports 0-6, 12, 15
// - fast data register holds one bit per pin
// - set select bit: fast data drives pin
// - clear select bit: hub data drives pin
// - pin state register is read-only, live pins
// - fast path subset; hub path reaches all
`ifndef XDATA_PORT_MAP_SVH
`define XDATA_PORT_MAP_SVH

////////////////////////////////////////////////////////////////////////////
// sfr addresses
`define SFR_PTR_SELECT     8'h86
`define SFR_PTR0_HIGH      8'h93
`define SFR_PTR1_HIGH      8'h95
`define SFR_IND_HIGH       8'h97
`define SFR_IND_MIDDLE     8'h9A
`define SFR_FAST_DR_BASE   8'hA0
`define SFR_FAST_SEL_BASE  8'hB0
`define SFR_FAST_PS_BASE   8'hC0

////////////////////////////////////////////////////////////////////////////
// fields and reset values
`define PTR_SELECT_BIT     0
`define RST_BYTE           8'h00
`define RST_PTR_SELECT     1'b0
`define UNMAPPED_READ      8'h00
`define FAST_PORT_COUNT    9
`define XADDR_WIDTH        24

`endif

// [hdl/xdata_port_pkg.sv]
`default_nettype none
package xdata_port_pkg;

   typedef enum logic [1:0] {
      MOVE_NONE,
      MOVE_VIA_POINTER,
      MOVE_VIA_INDIRECT
   } move_kind_e;

   typedef logic [7:0]  sfr_byte_t;
   typedef logic [23:0] xaddr_t;

   // physical port number served by each fast slot
   function automatic logic [3:0] fast_port_number(input int slot);
      logic [3:0] n;
      n = 4'h0;
      if (slot < 7) begin
         n = 4'(slot);
      end else if (slot == 7) begin
         n = 4'hC;
      end else begin
         n = 4'hF;
      end
      return n;
   endfunction

endpackage
`default_nettype wire

// [hdl/fast_port_slice.sv]
`default_nettype none
`include "xdata_port_map.svh"
module fast_port_slice
   import xdata_port_pkg::*;
#(
   parameter int PIN_COUNT = 8
) (
   input  wire logic                 mclk,
   input  wire logic                 rst,
   input  wire logic                 wr_data,
   input  wire logic                 wr_select,
   input  wire logic [PIN_COUNT-1:0] wdata,
   input  wire logic [PIN_COUNT-1:0] hub_port_output_data,
   output logic      [PIN_COUNT-1:0] data_q,
   output logic      [PIN_COUNT-1:0] select_q,
   output logic      [PIN_COUNT-1:0] pin_out
);

   logic [PIN_COUNT-1:0] data_reg;
   logic [PIN_COUNT-1:0] data_next;
   logic [PIN_COUNT-1:0] select_reg;
   logic [PIN_COUNT-1:0] select_next;
   logic [PIN_COUNT-1:0] pin_reg;
   logic [PIN_COUNT-1:0] pin_next;

   assign data_next   = wr_data ? wdata : data_reg;
   assign select_next = wr_select ? wdata : select_reg;

   // per-pin source; next values so a write shows on the same edge
   genvar y;
   generate
      for (y = 0; y < PIN_COUNT; y = y + 1) begin : g_pin
         assign pin_next[y] = select_next[y] ? data_next[y]
                                             : hub_port_output_data[y];
      end
   endgenerate

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         data_reg   <= '0;
         select_reg <= '0;
         pin_reg    <= '0;
      end else begin
         data_reg   <= data_next;
         select_reg <= select_next;
         pin_reg    <= pin_next;
      end
   end

   assign data_q   = data_reg;
   assign select_q = select_reg;
   assign pin_out  = pin_reg;

endmodule // fast_port_slice
`default_nettype wire

// [hdl/xdata_port_sfr.sv]
`default_nettype none
`include "xdata_port_map.svh"
module xdata_port_sfr
   import xdata_port_pkg::*;
#(
   parameter int PORTS = `FAST_PORT_COUNT,
   parameter int PINS  = 8
) (
   input  wire logic                       mclk,
   input  wire logic                       rst,
   // sfr access from the core
   input  wire logic [7:0]                 sfr_addr,
   input  wire logic                       sfr_wr,
   input  wire logic                       sfr_rd,
   input  wire logic [7:0]                 sfr_wdata,
   output logic      [7:0]                 sfr_rdata,
   // external data move address request from the core
   input  wire logic                       move_strobe,
   input  wire move_kind_e                 move_kind,
   input  wire logic [15:0]                move_low_addr,
   output logic                            pointer_select,
   output logic      [`XADDR_WIDTH-1:0]    xaddr,
   output logic                            xaddr_valid,
   // port side
   input  wire logic [PORTS-1:0][PINS-1:0] hub_port_output_data,
   input  wire logic [PORTS-1:0][PINS-1:0] pin_level,
   output logic      [PORTS-1:0][PINS-1:0] pin_out
);

   ////////////////////////////////////////////////////////////////////////
   // decode helpers

   function automatic logic slot_match(
      input logic [7:0] addr,
      input logic [7:0] base,
      input int         slot
   );
      return addr == (base + 8'(slot));
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // extension and pointer select registers

   logic       ptr_sel_reg;
   logic       ptr_sel_next;
   sfr_byte_t  ptr0_high_reg;
   sfr_byte_t  ptr0_high_next;
   sfr_byte_t  ptr1_high_reg;
   sfr_byte_t  ptr1_high_next;
   sfr_byte_t  ind_high_reg;
   sfr_byte_t  ind_high_next;
   sfr_byte_t  ind_mid_reg;
   sfr_byte_t  ind_mid_next;

   wire hit_ptr_sel = (sfr_addr == `SFR_PTR_SELECT);
   wire hit_ptr0    = (sfr_addr == `SFR_PTR0_HIGH);
   wire hit_ptr1    = (sfr_addr == `SFR_PTR1_HIGH);
   wire hit_ind_hi  = (sfr_addr == `SFR_IND_HIGH);
   wire hit_ind_mid = (sfr_addr == `SFR_IND_MIDDLE);

   assign ptr_sel_next   = (sfr_wr && hit_ptr_sel)
                           ? sfr_wdata[`PTR_SELECT_BIT] : ptr_sel_reg;
   assign ptr0_high_next = (sfr_wr && hit_ptr0) ? sfr_wdata : ptr0_high_reg;
   assign ptr1_high_next = (sfr_wr && hit_ptr1) ? sfr_wdata : ptr1_high_reg;
   assign ind_high_next  = (sfr_wr && hit_ind_hi) ? sfr_wdata : ind_high_reg;
   assign ind_mid_next   = (sfr_wr && hit_ind_mid) ? sfr_wdata : ind_mid_reg;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ptr_sel_reg   <= `RST_PTR_SELECT;
         ptr0_high_reg <= `RST_BYTE;
         ptr1_high_reg <= `RST_BYTE;
         ind_high_reg  <= `RST_BYTE;
         ind_mid_reg   <= `RST_BYTE;
      end else begin
         ptr_sel_reg   <= ptr_sel_next;
         ptr0_high_reg <= ptr0_high_next;
         ptr1_high_reg <= ptr1_high_next;
         ind_high_reg  <= ind_high_next;
         ind_mid_reg   <= ind_mid_next;
      end
   end

   // the core steers all pointer-based instructions from this bit
   assign pointer_select = ptr_sel_reg;

   ////////////////////////////////////////////////////////////////////////
   // extended address forming

   // pointer moves use the select value of this very cycle, so a select
   // write in the same cycle as a move leaves it the old pointer; the core
   // serialises sfr writes before the next instruction anyway
   wire        via_pointer  = move_strobe && (move_kind == MOVE_VIA_POINTER);
   wire        via_indirect = move_strobe && (move_kind == MOVE_VIA_INDIRECT);
   wire        is_move      = via_pointer || via_indirect;
   wire [7:0]  ptr_top      = ptr_sel_reg ? ptr1_high_reg : ptr0_high_reg;

   xaddr_t addr_pointer;
   xaddr_t addr_indirect;
   xaddr_t xaddr_next;
   logic   xaddr_valid_next;
   xaddr_t xaddr_reg;
   logic   xaddr_valid_reg;

   assign addr_pointer  = {ptr_top, move_low_addr};
   assign addr_indirect = {ind_high_reg, ind_mid_reg,
                           move_low_addr[7:0]};

   // other instructions leave the last address untouched
   assign xaddr_next       = via_pointer  ? addr_pointer  :
                             via_indirect ? addr_indirect : xaddr_reg;
   assign xaddr_valid_next = is_move;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         xaddr_reg       <= '0;
         xaddr_valid_reg <= 1'b0;
      end else begin
         xaddr_reg       <= xaddr_next;
         xaddr_valid_reg <= xaddr_valid_next;
      end
   end

   assign xaddr       = xaddr_reg;
   assign xaddr_valid = xaddr_valid_reg;

   ////////////////////////////////////////////////////////////////////////
   // fast port slots

   logic [PORTS-1:0]            hit_dr;
   logic [PORTS-1:0]            hit_sel;
   logic [PORTS-1:0]            hit_ps;
   logic [PORTS-1:0][PINS-1:0]  dr_q;
   logic [PORTS-1:0][PINS-1:0]  sel_q;
   logic [PORTS-1:0][PINS-1:0]  slot_rdata;

   genvar p;
   generate
      for (p = 0; p < PORTS; p = p + 1) begin : g_port
         assign hit_dr[p]  = slot_match(sfr_addr, `SFR_FAST_DR_BASE, p);
         assign hit_sel[p] = slot_match(sfr_addr, `SFR_FAST_SEL_BASE, p);
         assign hit_ps[p]  = slot_match(sfr_addr, `SFR_FAST_PS_BASE, p);

         // pin state has no write strobe at all, a write there is dropped
         fast_port_slice #(
            .PIN_COUNT (PINS)
         ) u_slice (
            .mclk                 (mclk),
            .rst                  (rst),
            .wr_data              (sfr_wr && hit_dr[p]),
            .wr_select            (sfr_wr && hit_sel[p]),
            .wdata                (sfr_wdata[PINS-1:0]),
            .hub_port_output_data (hub_port_output_data[p]),
            .data_q               (dr_q[p]),
            .select_q             (sel_q[p]),
            .pin_out              (pin_out[p])
         );

         assign slot_rdata[p] = ({PINS{hit_dr[p]}}  & dr_q[p])
                              | ({PINS{hit_sel[p]}} & sel_q[p])
                              | ({PINS{hit_ps[p]}}  & pin_level[p]);
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // read data

   logic [PINS-1:0] port_rdata;

   always_comb begin
      port_rdata = '0;
      for (int i = 0; i < PORTS; i++) begin
         port_rdata = port_rdata | slot_rdata[i];
      end
   end

   wire any_port_hit = |{hit_dr, hit_sel, hit_ps};

   sfr_byte_t rdata_sel;
   sfr_byte_t rdata_reg;
   sfr_byte_t rdata_next;

   assign rdata_sel =
      hit_ptr_sel  ? {7'h00, ptr_sel_reg} :
      hit_ptr0     ? ptr0_high_reg        :
      hit_ptr1     ? ptr1_high_reg        :
      hit_ind_hi   ? ind_high_reg         :
      hit_ind_mid  ? ind_mid_reg          :
      any_port_hit ? 8'(port_rdata)       : `UNMAPPED_READ;

   // data holds until the next read so the core may sample late
   assign rdata_next = sfr_rd ? rdata_sel : rdata_reg;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rdata_reg <= `RST_BYTE;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign sfr_rdata = rdata_reg;

endmodule // xdata_port_sfr
`default_nettype wire

// [verif/xdata_port_monitor.sv]
`default_nettype none
module xdata_port_monitor
   import xdata_port_pkg::*;
#(
   parameter int PORTS = 9,
   parameter int PINS  = 8
) (
   input wire logic                       mclk,
   input wire logic                       rst,
   input wire logic [7:0]                 sfr_addr,
   input wire logic                       sfr_wr,
   input wire logic                       sfr_rd,
   input wire logic [7:0]                 sfr_wdata,
   input wire logic [7:0]                 sfr_rdata,
   input wire logic                       move_strobe,
   input wire move_kind_e                 move_kind,
   input wire logic [15:0]                move_low_addr,
   input wire logic                       pointer_select,
   input wire logic [23:0]                xaddr,
   input wire logic                       xaddr_valid,
   input wire logic [PORTS-1:0][PINS-1:0] hub_port_output_data,
   input wire logic [PORTS-1:0][PINS-1:0] pin_level,
   input wire logic [PORTS-1:0][PINS-1:0] pin_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////
   move_valid_a: assert property (
      move_strobe && move_kind != MOVE_NONE |=>
      xaddr_valid) else $error("move not answered");
   move_refused_a: assert property (
      !(move_strobe && move_kind != MOVE_NONE)
      |=> !xaddr_valid && $stable(xaddr)) else $error("idle move");
   pointer_low_a: assert property (
      move_strobe && move_kind ==
      MOVE_VIA_POINTER |=> xaddr[15:0] == $past(move_low_addr))
      else $error("pointer low bytes");
   indirect_low_a: assert property (
      move_strobe && move_kind ==
      MOVE_VIA_INDIRECT |=> xaddr[7:0] == $past(move_low_addr[7:0]))
      else $error("indirect low byte");
   select_write_a: assert property (
      sfr_wr && sfr_addr == 8'h86 |=>
      pointer_select == $past(sfr_wdata[0])) else $error("select");
   select_hold_a: assert property (
      !(sfr_wr && sfr_addr == 8'h86) |=>
      $stable(pointer_select)) else $error("select moved");
   pin_read_a: assert property (
      sfr_rd && sfr_addr[7:4] == 4'hC &&
      sfr_addr[3:0] < 4'h9 |=> sfr_rdata == $past(pin_level[sfr_addr[3:0]]))
      else $error("pin state read");
   unmapped_read_a: assert property (
      sfr_rd && sfr_addr[7:4] == 4'hF |=>
      sfr_rdata == 8'h00) else $error("unmapped read");
   rdata_hold_a: assert property (
      !sfr_rd |=> $stable(sfr_rdata))
      else $error("read data moved");
endmodule // xdata_port_monitor
bind xdata_port_sfr xdata_port_monitor #(.PORTS(PORTS), .PINS(PINS)) u_mon (
   .mclk(mclk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
   .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
   .move_strobe(move_strobe), .move_kind(move_kind),
   .move_low_addr(move_low_addr), .pointer_select(pointer_select),
   .xaddr(xaddr), .xaddr_valid(xaddr_valid),
   .hub_port_output_data(hub_port_output_data), .pin_level(pin_level),
   .pin_out(pin_out));
`default_nettype wire

// [verif/pin_partner.sv]
`default_nettype none
module pin_partner (
   input  wire logic [8:0][7:0] pin_out,
   input  wire logic [8:0][7:0] inject,
   output logic      [8:0][7:0] pin_level
);
   timeunit 1ns;
   timeprecision 1ps;
   // outside loads may overpower a driven pin, so pins can differ
   assign pin_level = pin_out ^ inject;
endmodule // pin_partner
`default_nettype wire

// [verif/xdata_addr_ext_and_port_sfr_bench.sv]
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; \
   $display("BAD %0t %h %h", $time, (a), (b)); end end
module xdata_addr_ext_and_port_sfr_bench
   import xdata_port_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic            mclk = 0, rst = 1, sfr_wr = 0, sfr_rd = 0;
   logic            move_strobe = 0, pointer_select, xaddr_valid;
   logic [7:0]      sfr_addr = 0, sfr_wdata = 0, sfr_rdata, e;
   move_kind_e      move_kind = MOVE_NONE;
   logic [15:0]     move_low_addr = 0;
   logic [23:0]     xaddr, xa = 0;
   logic [8:0][7:0] hub = 0, inject = 0, pin_level, pin_out;
   logic [7:0]      m [0:255];
   int              err_count = 0, n_tests = 0, cyc = 0;
   xdata_port_sfr u_dut (.mclk(mclk), .rst(rst), .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
      .sfr_rdata(sfr_rdata), .move_strobe(move_strobe),
      .move_kind(move_kind), .move_low_addr(move_low_addr),
      .pointer_select(pointer_select), .xaddr(xaddr),
      .xaddr_valid(xaddr_valid), .hub_port_output_data(hub),
      .pin_level(pin_level), .pin_out(pin_out));
   pin_partner u_pins (.pin_out(pin_out), .inject(inject),
      .pin_level(pin_level));
   ////////////////////////////////////////////////////////////////////////
   always #20 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin
         err_count++;
         test_done();
      end
   end
   task test_done;
      if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   function automatic bit rw_ok(input logic [7:0] a);
      return a inside {8'h86, 8'h93, 8'h95, 8'h97, 8'h9A} ||
         (a[7:4] inside {4'hA, 4'hB} && a[3:0] < 4'h9);
   endfunction
   task wr(input logic [7:0] a, input logic [7:0] d);
      sfr_rd = 0; move_strobe = 0; sfr_wr = 1; sfr_addr = a; sfr_wdata = d;
      if (rw_ok(a)) m[a] = (a == 8'h86) ? {7'h00, d[0]} : d;
      @(posedge mclk); #2;
   endtask
   // model value is taken before the edge, as the design samples it
   task rd(input logic [7:0] a);
      sfr_wr = 0; move_strobe = 0; sfr_rd = 1; sfr_addr = a;
      e = rw_ok(a) ? m[a] : (a[7:4] == 4'hC && a[3:0] < 4'h9) ?
         pin_level[a[3:0]] : 8'h00;
      @(posedge mclk); #2;
      `CHK(sfr_rdata, e)
   endtask
   // reaches the unmapped top rows too
   task sweep;
      for (int a = 8'h80; a < 'h100; a++) rd(a[7:0]);
   endtask
   task pins;
      sfr_wr = 0; sfr_rd = 0; move_strobe = 0;
      repeat (2) @(posedge mclk);
      #2;
      for (int s = 0; s < 9; s++)
         `CHK(pin_out[s], (m[8'hB0+s] & m[8'hA0+s]) | (~m[8'hB0+s] & hub[s]))
   endtask
   task mv(input move_kind_e k, input logic [15:0] lo);
      if (k == MOVE_VIA_POINTER) xa = {m[m[8'h86][0] ? 8'h95 : 8'h93], lo};
      if (k == MOVE_VIA_INDIRECT) xa = {m[8'h97], m[8'h9A], lo[7:0]};
      sfr_wr = 0; sfr_rd = 0; move_strobe = 1; move_kind = k;
      move_low_addr = lo;
      @(posedge mclk); #2;
      `CHK(xaddr, xa)
      `CHK(xaddr_valid, k != MOVE_NONE)
      `CHK(pointer_select, m[8'h86][0])
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(81200));
      for (int i = 0; i < 256; i++) m[i] = 8'h00;
      repeat (6) @(posedge mclk);
      #2 rst = 0;
      sweep();
      hub = {$urandom, $urandom, $urandom};
      for (int a = 8'h80; a < 8'hD0; a++) wr(a[7:0], 8'($urandom));
      pins();
      sweep();
      hub = {$urandom, $urandom, $urandom};
      inject = {$urandom, $urandom, $urandom};
      pins();
      sweep();
      for (int i = 0; i < 16; i++) begin
         wr(8'h86, 8'($urandom));
         foreach (e[b]) wr(b[0] ? 8'h93 : 8'h95, 8'($urandom));
         wr(8'h97, 8'($urandom));
         wr(8'h9A, 8'($urandom));
         `CHK(xaddr, xa)
         mv(move_kind_e'($urandom_range(2)), 16'($urandom));
         mv(move_kind_e'($urandom_range(2)), 16'($urandom));
      end
      test_done();
   end
endmodule // xdata_addr_ext_and_port_sfr_bench
`default_nettype wire
